/* File: opmc_core.sv */
// operator panel mode control: auto/manual switch, jog/continuous, lamps
// assumes panel buttons and key detect are asynchronous pins, active high
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps

module opmc_core (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // panel pins
  input wire logic [opmc_pkg::NUM_BTN-1:0] btn_i,
  input wire logic key_present_i,
  input wire logic panel_link_ok_i,
  // relay side state
  input wire opmc_pkg::opmc_dir_t auto_cmd_i,
  input wire logic group_error_i,
  input wire logic fatal_fault_i,
  input wire logic panel_ready_i,
  // register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // outputs
  output opmc_pkg::opmc_dir_t relay_o,
  output opmc_pkg::opmc_lamp_t lamp_o,
  output logic irq_o
);
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_CLEAR = 2'h1;
  localparam logic [1:0] ADDR_ENABLE = 2'h2;
  localparam logic [1:0] ADDR_STATE = 2'h3;

  logic [opmc_pkg::NUM_BTN-1:0] btn_s1_q, btn_s2_q, btn_db_q, btn_prev_q, press;
  logic key_s1_q, key_s2_q, link_s1_q, link_s2_q;
  logic manual_q, cont_q, link_trip_q, link_prev_q;
  logic [1:0] dir_q;
  logic [27:0] sel_cnt_q;
  logic sel_done_q;
  logic [23:0] flash_cnt_q;
  logic flash_q;
  logic [3:0] confirm_q;
  logic [2:0] irq_stat_q, irq_en_q;
  logic [2:0] ev;
  logic link_ok;

  // two stages before any logic looks at a pin
  always_ff @(posedge clk_sys_i)
  begin
    btn_s1_q <= btn_i;
    btn_s2_q <= btn_s1_q;
    key_s1_q <= key_present_i;
    key_s2_q <= key_s1_q;
    // preset healthy so a reset release cannot fake a link-loss event
    link_s1_q <= rst_i ? 1'h1 : panel_link_ok_i;
    link_s2_q <= rst_i ? 1'h1 : link_s1_q;
  end
  assign link_ok = link_s2_q;

  // per-button debounce: accept a level only after it is stable
  genvar gi;
  generate
    for (gi = 0; gi < opmc_pkg::NUM_BTN; gi++)
    begin : g_db
      logic [18:0] cnt_q;
      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          cnt_q <= 19'h0;
          btn_db_q[gi] <= 1'h0;
        end
        else if (btn_s2_q[gi] == btn_db_q[gi])
          cnt_q <= 19'h0;
        else if (cnt_q == 19'(opmc_pkg::DEBOUNCE_CYC - 1))
        begin
          cnt_q <= 19'h0;
          btn_db_q[gi] <= btn_s2_q[gi];
        end
        else
          cnt_q <= cnt_q + 19'h1;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      btn_prev_q <= '0;
    else
      btn_prev_q <= btn_db_q;
  end
  // press edges only count with the key inserted
  assign press = (btn_db_q & ~btn_prev_q) & {opmc_pkg::NUM_BTN{key_s2_q}};

  // auto/manual mode; return to auto refused while a relay is on
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      manual_q <= opmc_pkg::MANUAL_RST;
    else if (press[opmc_pkg::BTN_MANUAL])
    begin
      if (!manual_q)
        manual_q <= 1'h1;
      else if (dir_q == 2'h0)
        manual_q <= 1'h0;
    end
  end

  // select hold timer, one toggle per hold
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sel_cnt_q <= 28'h0;
      sel_done_q <= 1'h0;
      cont_q <= opmc_pkg::CONT_RST;
    end
    else if (!(manual_q && key_s2_q && btn_db_q[opmc_pkg::BTN_SELECT]))
    begin
      sel_cnt_q <= 28'h0;
      sel_done_q <= 1'h0;
    end
    else if (!sel_done_q)
    begin
      if (sel_cnt_q == 28'(opmc_pkg::SELECT_HOLD_CYC))
      begin
        cont_q <= ~cont_q;
        sel_done_q <= 1'h1;
      end
      else
        sel_cnt_q <= sel_cnt_q + 28'h1;
    end
  end

  // link loss trip latch, cleared on leaving manual mode
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      link_trip_q <= 1'h0;
      link_prev_q <= 1'h1;
    end
    else
    begin
      link_prev_q <= link_ok;
      if (manual_q && !link_ok)
        link_trip_q <= 1'h1;
      else if (!manual_q)
        link_trip_q <= 1'h0;
    end
  end

  // manual direction state; both directions never on together
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !manual_q || link_trip_q || !link_ok)
      dir_q <= opmc_pkg::DIR_RST;
    else if (!cont_q)
    begin
      if (key_s2_q && btn_db_q[opmc_pkg::BTN_DIR1] && !btn_db_q[opmc_pkg::BTN_DIR2])
        dir_q <= 2'h1;
      else if (key_s2_q && btn_db_q[opmc_pkg::BTN_DIR2] && !btn_db_q[opmc_pkg::BTN_DIR1])
        dir_q <= 2'h2;
      else
        dir_q <= 2'h0;
    end
    else if (press[opmc_pkg::BTN_DIR1])
      dir_q <= dir_q[0] ? 2'h0 : 2'h1;
    else if (press[opmc_pkg::BTN_DIR2])
      dir_q <= dir_q[1] ? 2'h0 : 2'h2;
  end

  // relay drive: panel in manual, process image in auto
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      relay_o <= '0;
    else if (manual_q)
      relay_o <= {dir_q[1], dir_q[0]};
    else if (auto_cmd_i.dir1 && auto_cmd_i.dir2)
      relay_o <= '0;
    else
      relay_o <= auto_cmd_i;
  end

  // flash base and submode confirm burst
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      flash_cnt_q <= 24'h0;
      flash_q <= 1'h0;
    end
    else if (flash_cnt_q == 24'(opmc_pkg::FLASH_CYC - 1))
    begin
      flash_cnt_q <= 24'h0;
      flash_q <= ~flash_q;
    end
    else
      flash_cnt_q <= flash_cnt_q + 24'h1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      confirm_q <= 4'h0;
    else if (ev[opmc_pkg::IRQ_SUBMODE])
      confirm_q <= 4'(opmc_pkg::CONFIRM_FLASHES);
    else if (confirm_q != 4'h0 && flash_cnt_q == 24'h0)
      confirm_q <= confirm_q - 4'h1;
  end

  // direction lamps track relay outputs in every mode
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      lamp_o <= '0;
    else
    begin
      lamp_o.dir1 <= relay_o.dir1;
      lamp_o.dir2 <= relay_o.dir2;
      lamp_o.manual <= (confirm_q != 4'h0) ? confirm_q[0] : manual_q;
      lamp_o.group_error <= group_error_i || link_trip_q;
      lamp_o.fault <= !link_ok ? 1'h1 : (fatal_fault_i & flash_q);
      lamp_o.panel_ready <= panel_ready_i && link_ok;
    end
  end

  // events: manual toggle, submode toggle, link loss
  assign ev[opmc_pkg::IRQ_MANUAL] = press[opmc_pkg::BTN_MANUAL] && (!manual_q || dir_q == 2'h0);
  assign ev[opmc_pkg::IRQ_SUBMODE] = manual_q && key_s2_q && btn_db_q[opmc_pkg::BTN_SELECT]
    && !sel_done_q && sel_cnt_q == 28'(opmc_pkg::SELECT_HOLD_CYC);
  assign ev[opmc_pkg::IRQ_LINKLOSS] = link_prev_q && !link_ok;

  // sticky status: a set in the clear cycle wins
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      irq_stat_q <= 3'h0;
      irq_en_q <= 3'h0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == ADDR_CLEAR)
        irq_stat_q <= (irq_stat_q & ~reg_wdata_i[2:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
      if (reg_wr_i && reg_addr_i == ADDR_ENABLE)
        irq_en_q <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      irq_o <= 1'h0;
    else
      irq_o <= |(irq_stat_q & irq_en_q);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h0;
    else if (reg_rd_i)
      case (reg_addr_i)
        ADDR_STATUS: reg_rdata_o <= {5'h0, irq_stat_q};
        ADDR_ENABLE: reg_rdata_o <= {5'h0, irq_en_q};
        ADDR_STATE: reg_rdata_o <= {2'h0, key_s2_q, link_trip_q, dir_q, cont_q, manual_q};
        default: reg_rdata_o <= 8'h0;
      endcase
    else
      reg_rdata_o <= 8'h0;
  end

  // checks
  one_dir_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !(relay_o.dir1 && relay_o.dir2)) else $error("both relays on");
  no_key_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !key_s2_q && !cont_q |=> dir_q == 2'h0) else $error("direction on without key");
  jog_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    manual_q && !cont_q && !btn_db_q[opmc_pkg::BTN_DIR1] |=> !dir_q[0])
    else $error("jog relay held after release");
  cont_toggle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    manual_q && cont_q && link_ok && !link_trip_q && press[opmc_pkg::BTN_DIR1] && dir_q[0]
    |=> dir_q == 2'h0) else $error("continuous stop missed");
  auto_follow_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !manual_q && !(auto_cmd_i.dir1 && auto_cmd_i.dir2) |=> relay_o == $past(auto_cmd_i))
    else $error("auto command not applied");
  leave_busy_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    manual_q && dir_q != 2'h0 && press[opmc_pkg::BTN_MANUAL] |=> manual_q)
    else $error("left manual with relay on");
  link_trip_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    manual_q && !link_ok |=> ##1 lamp_o.group_error && relay_o == '0)
    else $error("link loss not tripped");
  fault_lamp_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !link_ok |=> lamp_o.fault) else $error("fault lamp dark on link loss");
  dir_lamp_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ##1 lamp_o.dir1 == $past(relay_o.dir1)) else $error("direction lamp wrong");
  jog_reset_a: assert property (@(posedge clk_sys_i)
    $fell(rst_i) |-> !cont_q) else $error("not jog after reset");
  manual_lamp_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(manual_q) && confirm_q == 4'h0 |=> lamp_o.manual) else $error("manual lamp dark");
  group_lamp_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    group_error_i |=> lamp_o.group_error) else $error("group error lamp dark");

  enter_manual_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(manual_q));
  submode_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(cont_q));
  cont_run_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) cont_q && dir_q != 2'h0);
  back_auto_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) $fell(manual_q));
endmodule : opmc_core

/* File: opmc_panel_model.sv */
// operator panel stand-in: buttons, enabling key module and link health
// assumes the bench commands presses; lamps come back from the relay side
`timescale 1ns/100ps
module opmc_panel_model (
  // clock
  input wire logic clk_sys_i,
  // bench commands
  input wire logic [3:0] press_i,
  input wire logic key_req_i,
  input wire logic link_req_i,
  // lamps from the relay
  input wire opmc_pkg::opmc_lamp_t lamp_i,
  // panel pins
  output logic [3:0] btn_o,
  output logic key_o,
  output logic link_ok_o
);
  logic relay_idle;
  logic [3:0] btn_d;

  assign relay_idle = !lamp_i.dir1 && !lamp_i.dir2;

  // an operator asks for auto only once both direction lamps are dark
  always_comb
  begin
    btn_d = press_i;
    btn_d[opmc_pkg::BTN_MANUAL] = press_i[opmc_pkg::BTN_MANUAL]
      && (relay_idle || !lamp_i.manual);
  end

  always_ff @(posedge clk_sys_i)
  begin
    btn_o <= btn_d;
    // key stays in while the manual lamp is lit
    key_o <= key_req_i || lamp_i.manual;
    link_ok_o <= link_req_i;
  end
endmodule : opmc_panel_model

/* File: opmc_pkg.sv */
// package for the operator panel mode control: timing, lamp modes, carriers
// assumes a 40 MHz system clock
package opmc_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int SELECT_HOLD_MS = 5000;
  localparam int SELECT_HOLD_CYC = (CLK_HZ / 1000) * SELECT_HOLD_MS;
  // short filter keeps a bench press affordable; raise it for bouncy switches
  localparam int DEBOUNCE_US = 100;
  localparam int DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
  localparam int CONFIRM_FLASHES = 6;
  localparam int NUM_BTN = 4;
  localparam int BTN_MANUAL = 0;
  localparam int BTN_SELECT = 1;
  localparam int BTN_DIR1 = 2;
  localparam int BTN_DIR2 = 3;
  localparam int IRQ_MANUAL = 0;
  localparam int IRQ_SUBMODE = 1;
  localparam int IRQ_LINKLOSS = 2;
  localparam logic [1:0] DIR_RST = 2'h0;
  localparam logic MANUAL_RST = 1'h0;
  localparam logic CONT_RST = 1'h0;

  typedef struct packed {
    logic dir2;
    logic dir1;
  } opmc_dir_t;

  typedef struct packed {
    logic panel_ready;
    logic fault;
    logic group_error;
    logic manual;
    logic dir2;
    logic dir1;
  } opmc_lamp_t;
endpackage : opmc_pkg

/* File: test_opmc_core.sv */
// self-checking bench for the panel mode control core
// assumes 40 MHz clock; the 5 s select hold is too long to run, so jog submode only
`timescale 1ns/100ps
module test_opmc_core;
  logic clk_sys_i, rst_i, key_req, link_req, group_error_i, fatal_fault_i, panel_ready_i;
  logic key_present_i, panel_link_ok_i, reg_wr_i, reg_rd_i, irq_o;
  logic [3:0] press, btn_i;
  logic [1:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  opmc_pkg::opmc_dir_t auto_cmd_i, relay_o;
  opmc_pkg::opmc_lamp_t lamp_o;
  int failures, comparisons;

  opmc_core uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .btn_i(btn_i),
    .key_present_i(key_present_i), .panel_link_ok_i(panel_link_ok_i),
    .auto_cmd_i(auto_cmd_i), .group_error_i(group_error_i), .fatal_fault_i(fatal_fault_i),
    .panel_ready_i(panel_ready_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .relay_o(relay_o), .lamp_o(lamp_o), .irq_o(irq_o));

  opmc_panel_model panel (.clk_sys_i(clk_sys_i), .press_i(press), .key_req_i(key_req),
    .link_req_i(link_req), .lamp_i(lamp_o), .btn_o(btn_i), .key_o(key_present_i),
    .link_ok_o(panel_link_ok_i));

  initial
  begin
    clk_sys_i = 1'h0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'h0;
    #1;
    check("reg_rdata", reg_rdata_o & mask, exp);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : settle

  // change the panel buttons, then wait out the debounce filter
  task automatic push(input logic [3:0] b);
    @(posedge clk_sys_i);
    press <= b;
    settle(opmc_pkg::DEBOUNCE_CYC + 20);
  endtask : push

  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  initial
  begin
    logic [1:0] cmd;
    int n;
    failures = 0;
    comparisons = 0;
    rst_i = 1'h1;
    press = 4'h0;
    key_req = 1'h0;
    link_req = 1'h1;
    auto_cmd_i = 2'h0;
    group_error_i = 1'h0;
    fatal_fault_i = 1'h0;
    panel_ready_i = 1'h0;
    reg_addr_i = 2'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'h0;
    reg_rd_i = 1'h0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    settle(10);
    check("relay_after_reset", 8'(relay_o), 8'h00);
    rd(2'h3, 8'hFF, 8'h00);
    rd(2'h0, 8'hFF, 8'h00);
    rd(2'h2, 8'hFF, 8'h00);
    $display("test reset done");

    for (int i = 0; i < 4; i++)
    begin
      cmd = 2'(i);
      @(posedge clk_sys_i);
      auto_cmd_i <= cmd;
      settle(1);
      check("relay_auto", 8'(relay_o), (cmd == 2'h3) ? 8'h00 : 8'(cmd));
      settle(1);
      check("lamp_dir", 8'({lamp_o.dir2, lamp_o.dir1}), (cmd == 2'h3) ? 8'h00 : 8'(cmd));
    end
    $display("test auto follow done");

    @(posedge clk_sys_i);
    auto_cmd_i <= 2'h1;
    press <= 4'hF;
    settle(60);
    check("relay_key_absent", 8'(relay_o), 8'h01);
    rd(2'h3, 8'h21, 8'h00);
    @(posedge clk_sys_i);
    press <= 4'h0;
    $display("test key absent done");

    @(posedge clk_sys_i);
    group_error_i <= 1'h1;
    panel_ready_i <= 1'h1;
    settle(4);
    check("group_error_lamp", 8'(lamp_o.group_error), 8'h01);
    check("ready_lamp", 8'(lamp_o.panel_ready), 8'h01);
    check("fault_lamp_ok", 8'(lamp_o.fault), 8'h00);
    check("lamp_dir_monitor", 8'(lamp_o.dir1), 8'h01);
    @(posedge clk_sys_i);
    group_error_i <= 1'h0;
    settle(4);
    check("group_error_dark", 8'(lamp_o.group_error), 8'h00);
    $display("test lamps done");

    wr(2'h2, 8'h04);
    link_req <= 1'h0;
    n = 0;
    while (irq_o !== 1'h1 && n < 50)
    begin
      settle(1);
      n++;
    end
    if (irq_o !== 1'h1)
    begin
      failures++;
      results();
    end
    check("fault_lamp_link", 8'(lamp_o.fault), 8'h01);
    check("ready_lamp_link", 8'(lamp_o.panel_ready), 8'h00);
    rd(2'h0, 8'hFF, 8'h04);
    wr(2'h2, 8'h00);
    settle(3);
    check("irq_masked", 8'(irq_o), 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h1, 8'hFF, 8'h00);
    wr(2'h2, 8'h04);
    settle(3);
    check("irq_enabled", 8'(irq_o), 8'h01);
    wr(2'h1, 8'h04);
    settle(3);
    check("irq_cleared", 8'(irq_o), 8'h00);
    rd(2'h0, 8'hFF, 8'h00);
    @(posedge clk_sys_i);
    link_req <= 1'h1;
    settle(8);
    check("fault_lamp_back", 8'(lamp_o.fault), 8'h00);
    $display("test link and irq done");

    @(posedge clk_sys_i);
    key_req <= 1'h1;
    settle(5);
    push(4'h1);
    check("manual_lamp_on", 8'(lamp_o.manual), 8'h01);
    check("relay_manual_idle", 8'(relay_o), 8'h00);
    rd(2'h3, 8'hFF, 8'h21);
    rd(2'h0, 8'h01, 8'h01);
    push(4'h0);
    push(4'h4);
    check("relay_jog_held", 8'(relay_o), 8'h01);
    check("lamp_jog_dir1", 8'(lamp_o.dir1), 8'h01);
    push(4'h0);
    check("relay_jog_released", 8'(relay_o), 8'h00);
    $display("test manual jog done");

    push(4'h4);
    @(posedge clk_sys_i);
    link_req <= 1'h0;
    settle(10);
    check("relay_link_trip", 8'(relay_o), 8'h00);
    check("group_lamp_trip", 8'(lamp_o.group_error), 8'h01);
    rd(2'h3, 8'hFF, 8'h31);
    @(posedge clk_sys_i);
    link_req <= 1'h1;
    settle(10);
    check("group_lamp_latched", 8'(lamp_o.group_error), 8'h01);
    check("relay_trip_held", 8'(relay_o), 8'h00);
    push(4'h0);
    push(4'h1);
    check("manual_lamp_off", 8'(lamp_o.manual), 8'h00);
    check("relay_auto_resume", 8'(relay_o), 8'h01);
    check("group_lamp_auto", 8'(lamp_o.group_error), 8'h00);
    push(4'h0);
    @(posedge clk_sys_i);
    key_req <= 1'h0;
    settle(5);
    rd(2'h3, 8'hFF, 8'h00);
    $display("test manual exit done");
    results();
  end
endmodule : test_opmc_core
